// *** design/cwl_config_map.vh ***
// register offsets, field positions and codes of the configuration word loader
`ifndef CWL_CONFIG_MAP_VH
`define CWL_CONFIG_MAP_VH
// ----------------------------------------
// configuration word offsets (printed, flash word address = byte offset)
// ----------------------------------------
`define CWL_OFF_SEC 24'h002b80
`define CWL_OFF_BOOTLIM 24'h002b90
`define CWL_OFF_SIGN 24'h002b94
`define CWL_OFF_OSCSEL 24'h002b98
`define CWL_OFF_OSC 24'h002b9c
`define CWL_OFF_WDT 24'h002ba0
`define CWL_OFF_POR 24'h002ba4
`define CWL_OFF_ICD 24'h002ba8
`define CWL_OFF_DEVOPT 24'h002bac
`define CWL_OFF_ALTREG 24'h002bb0
`define CWL_OFF_BTSEQ 24'h002bfc
`define CWL_OFF_BOOT 24'h801000
// second partition lies this far above the first
`define CWL_PART2_BASE 24'h400000
// ----------------------------------------
// apb status and decode registers (extra)
// ----------------------------------------
`define CWL_OFF_STATUS 24'h002c00
`define CWL_OFF_DECODE 24'h002c04
// ----------------------------------------
// field positions, width, codes and word count
// ----------------------------------------
`define CWL_SEC_BOOT_WP 0
`define CWL_SEC_BOOT_LVL_LO 1
`define CWL_SEC_BOOT_CTL 3
`define CWL_SEC_GEN_WP 5
`define CWL_SEC_GEN_LVL_LO 6
`define CWL_SEC_CFG_WP 8
`define CWL_SEC_CFG_LVL_LO 9
`define CWL_SEC_AIVT 15
`define CWL_OSCSEL_TWO_SPEED 7
`define CWL_OSC_CLKSW_LO 6
`define CWL_WDT_PRE 4
`define CWL_WDT_EN_LO 5
`define CWL_WDT_WIN_OFF 7
`define CWL_WDT_WIN_LO 8
`define CWL_ICD_SWAP_OFF 15
`define CWL_DEVOPT_PWM_KEY 0
`define CWL_ALT_SET2_LO 4
`define CWL_SEQ_W 12
`define CWL_BOOT_SINGLE 2'h3
`define CWL_NWORDS 4'hb
`define CWL_PRIO_RESERVED 3'h7
`endif

// *** design/cwl_config_word_loader.v ***
// configuration word loader: flash to shadow copy, decode and apb readback
//
// Behaviour
// R1: every reset copies config words from flash
// R2: dual partition uses lower boot sequence number
// R3: sequence valid only when inverse is complement
// R4: soft swap keeps settings of last reset
// R5: executing from config space causes device reset
// R6: last page erase clears configuration words
// R7: programmer writes reserved bits per convention
// R8: boot/general protection level decode
// R9: boot segment enable and page limit
// R10: write protect bits low block writes
// R11: config segment protection level decode
// R12: swap instruction disabled when bit set
// R13: alternate vector table needs bit clear, intcon
// R14: two-speed startup selects fast rc first
// R15: pwm lock requires key sequence
// R16: reset oscillator selection decode
// R17: clock switch and monitor mode decode
// R18: watchdog enable mode decode
// R19: watchdog prescaler and postscaler selection
// R20: watchdog window mode and size
// R21: boot mode selects flash partitioning
// R22: alternate register set priority is code+1; outputs carry the raw 3-bit code
// R23: hold dependents until load completes
// R24: shadows stable until next reset
`timescale 1ns/10ps
`include "cwl_config_map.vh"
module cwl_config_word_loader (
   input wire sys_clk,
   input wire rst,
   // flash read port (synchronous, any latency, data marked by flashRdValid)
   output reg flashRdEn_ff,
   output reg [23:0] flashAddr_ff,
   input wire [23:0] flashRdData,
   input wire flashRdValid,
   // page erase on the last page is done by the flash, which clears these words (R6)
   input wire softSwapReq,
   input wire fetchFromCfgSpace,
   input wire intconAltVector,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // decoded settings
   output reg cfgDone_ff,
   output reg deviceResetReq_ff,
   output reg activePartition_ff,
   output reg [1:0] bootProtectLevel_ff,
   output reg bootSegmentEnabled_ff,
   output reg [12:0] bootPageLimit_ff,
   output reg bootWriteBlock_ff,
   output reg [1:0] generalProtectLevel_ff,
   output reg generalWriteBlock_ff,
   output reg cfgWriteBlock_ff,
   output reg [1:0] cfgProtectLevel_ff,
   output reg swapInstrAllowed_ff,
   output reg altVectorTableOn_ff,
   output reg twoSpeedStartup_ff,
   output reg pwmKeyRequired_ff,
   output reg [2:0] resetOscSelect_ff,
   output reg clockSwitchEnable_ff,
   output reg failSafeMonitorEnable_ff,
   output reg [1:0] watchdogEnableMode_ff,
   output reg [7:0] watchdogPrescale_ff,
   output reg [3:0] watchdogPostscaleSelect_ff,
   output reg watchdogWindowMode_ff,
   output reg [1:0] watchdogWindowSize_ff,
   output reg [1:0] flashPartitionMode_ff,
   output reg [2:0] altRegset1Priority_ff,
   output reg [2:0] altRegset2Priority_ff
);
   // ----------------------------------------
   // loader state machine
   // ----------------------------------------
   localparam ST_BOOT = 3'h0;
   localparam ST_SEQ1 = 3'h1;
   localparam ST_SEQ2 = 3'h2;
   localparam ST_WORDS = 3'h3;
   localparam ST_WAIT = 3'h4;
   localparam ST_DONE = 3'h5;

   reg [2:0] state_ff;
   reg [3:0] wordIdx_ff;
   reg [23:0] bootMode_ff;
   reg [23:0] seq1_ff;
   reg partSel_ff;
   reg [23:0] shadow_ff [0:9];
   reg [3:0] i;

   function [23:0] wordOffset;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: wordOffset = `CWL_OFF_SEC;
            4'h1: wordOffset = `CWL_OFF_BOOTLIM;
            4'h2: wordOffset = `CWL_OFF_SIGN;
            4'h3: wordOffset = `CWL_OFF_OSCSEL;
            4'h4: wordOffset = `CWL_OFF_OSC;
            4'h5: wordOffset = `CWL_OFF_WDT;
            4'h6: wordOffset = `CWL_OFF_POR;
            4'h7: wordOffset = `CWL_OFF_ICD;
            4'h8: wordOffset = `CWL_OFF_DEVOPT;
            4'h9: wordOffset = `CWL_OFF_ALTREG;
            4'ha: wordOffset = `CWL_OFF_BTSEQ;
            default: wordOffset = `CWL_OFF_BOOT;
         endcase
      end
   endfunction

   // valid sequence: inverse field is one's complement of number
   function seqValid;
      input [23:0] w;
      begin
         seqValid = (w[23:12] == ~w[11:0]); // R3
      end
   endfunction

   function [23:0] partBase;
      input p;
      begin
         partBase = p ? `CWL_PART2_BASE : 24'h000000;
      end
   endfunction

   wire dualMode = (bootMode_ff[1:0] != `CWL_BOOT_SINGLE);

   // partition choice: lower valid number wins; invalid one loses
   wire [23:0] seqB = flashRdData;
   wire pickSecond = seqValid(seqB) &&
      (!seqValid(seq1_ff) || (seqB[11:0] < seq1_ff[11:0])); // R2 R3

   // any device reset restarts the copy; soft swap never touches it
   always @(posedge sys_clk) begin
      if (rst) begin // R1
         state_ff <= ST_BOOT;
         wordIdx_ff <= 4'h0;
         flashRdEn_ff <= 1'b1;
         flashAddr_ff <= `CWL_OFF_BOOT;
         bootMode_ff <= 24'hffffff;
         seq1_ff <= 24'h000000;
         partSel_ff <= 1'b0;
         cfgDone_ff <= 1'b0;
      end else begin
         flashRdEn_ff <= 1'b0;
         case (state_ff)
            ST_BOOT: begin
               if (flashRdValid) begin
                  bootMode_ff <= flashRdData;
                  flashRdEn_ff <= 1'b1;
                  flashAddr_ff <= `CWL_OFF_BTSEQ;
                  state_ff <= (flashRdData[1:0] != `CWL_BOOT_SINGLE) ? ST_SEQ1 : ST_WAIT;
               end
            end
            ST_SEQ1: begin
               if (flashRdValid) begin
                  seq1_ff <= flashRdData;
                  flashRdEn_ff <= 1'b1;
                  flashAddr_ff <= `CWL_OFF_BTSEQ + `CWL_PART2_BASE;
                  state_ff <= ST_SEQ2;
               end
            end
            ST_SEQ2: begin
               if (flashRdValid) begin
                  partSel_ff <= pickSecond; // R2
                  flashRdEn_ff <= 1'b1;
                  flashAddr_ff <= wordOffset(4'h0) + partBase(pickSecond);
                  wordIdx_ff <= 4'h0;
                  state_ff <= ST_WORDS;
               end
            end
            ST_WAIT: begin
               // single partition: drain the unused sequence read first
               if (flashRdValid) begin
                  flashRdEn_ff <= 1'b1;
                  flashAddr_ff <= wordOffset(4'h0);
                  wordIdx_ff <= 4'h0;
                  state_ff <= ST_WORDS;
               end
            end
            ST_WORDS: begin
               if (flashRdValid) begin
                  if (wordIdx_ff == `CWL_NWORDS - 4'h2) begin
                     state_ff <= ST_DONE;
                     cfgDone_ff <= 1'b1; // R23
                  end else begin
                     wordIdx_ff <= wordIdx_ff + 4'h1;
                     flashRdEn_ff <= 1'b1;
                     flashAddr_ff <= wordOffset(wordIdx_ff + 4'h1) + partBase(partSel_ff);
                  end
               end
            end
            ST_DONE: begin
               state_ff <= ST_DONE;
            end
            default: state_ff <= ST_BOOT;
         endcase
      end
   end

   // shadows written only during the copy (R24, R4)
   always @(posedge sys_clk) begin
      if (rst) begin
         for (i = 4'h0; i < 4'ha; i = i + 4'h1) begin
            shadow_ff[i] <= 24'hffffff;
         end
      end else if (state_ff == ST_WORDS && flashRdValid) begin
         shadow_ff[wordIdx_ff] <= flashRdData; // R1 R24
      end
   end

   // ----------------------------------------
   // decode, held at safe values until load completes
   // ----------------------------------------
   wire [23:0] sec = shadow_ff[0];
   wire [23:0] osel = shadow_ff[3];
   wire [23:0] osc = shadow_ff[4];
   wire [23:0] wdt = shadow_ff[5];
   wire [23:0] icd = shadow_ff[7];
   wire [23:0] dev = shadow_ff[8];
   wire [23:0] alt = shadow_ff[9];
   wire [23:0] bsl = shadow_ff[1];
   wire loadFinished = (state_ff == ST_DONE);
   reg [1:0] cfgLevel;

   // protection level: 0 none, 1 standard, 2 enhanced, 3 high
   always @* begin
      casez (sec[`CWL_SEC_CFG_LVL_LO+2:`CWL_SEC_CFG_LVL_LO]) // R11
         3'b111: cfgLevel = 2'h0;
         3'b110: cfgLevel = 2'h1;
         3'b10?: cfgLevel = 2'h2;
         default: cfgLevel = 2'h3;
      endcase
   end

   function [1:0] segLevel;
      input [1:0] f;
      begin
         segLevel = (f == 2'h3) ? 2'h0 : ((f == 2'h2) ? 2'h1 : 2'h3); // R8
      end
   endfunction

   always @(posedge sys_clk) begin
      if (rst || !loadFinished) begin // R23
         bootProtectLevel_ff <= 2'h0;
         bootSegmentEnabled_ff <= 1'b0;
         bootPageLimit_ff <= 13'h1fff;
         bootWriteBlock_ff <= 1'b0;
         generalProtectLevel_ff <= 2'h0;
         generalWriteBlock_ff <= 1'b0;
         cfgWriteBlock_ff <= 1'b0;
         cfgProtectLevel_ff <= 2'h0;
         swapInstrAllowed_ff <= 1'b0;
         altVectorTableOn_ff <= 1'b0;
         twoSpeedStartup_ff <= 1'b0;
         pwmKeyRequired_ff <= 1'b0;
         resetOscSelect_ff <= 3'h0;
         clockSwitchEnable_ff <= 1'b0;
         failSafeMonitorEnable_ff <= 1'b0;
         watchdogEnableMode_ff <= 2'h0;
         watchdogPrescale_ff <= 8'h20;
         watchdogPostscaleSelect_ff <= 4'h0;
         watchdogWindowMode_ff <= 1'b0;
         watchdogWindowSize_ff <= 2'h0;
         flashPartitionMode_ff <= `CWL_BOOT_SINGLE;
         altRegset1Priority_ff <= 3'h0;
         altRegset2Priority_ff <= 3'h0;
         activePartition_ff <= 1'b0;
      end else begin
         bootProtectLevel_ff <= segLevel(sec[`CWL_SEC_BOOT_LVL_LO+1:`CWL_SEC_BOOT_LVL_LO]); // R8
         generalProtectLevel_ff <= segLevel(sec[`CWL_SEC_GEN_LVL_LO+1:`CWL_SEC_GEN_LVL_LO]); // R8
         bootSegmentEnabled_ff <= ~sec[`CWL_SEC_BOOT_CTL]; // R9
         bootPageLimit_ff <= ~bsl[12:0]; // R9
         bootWriteBlock_ff <= ~sec[`CWL_SEC_BOOT_WP]; // R10
         generalWriteBlock_ff <= ~sec[`CWL_SEC_GEN_WP]; // R10
         cfgWriteBlock_ff <= ~sec[`CWL_SEC_CFG_WP]; // R10
         cfgProtectLevel_ff <= cfgLevel; // R11
         swapInstrAllowed_ff <= ~icd[`CWL_ICD_SWAP_OFF]; // R12
         // table also needs a boot segment present
         altVectorTableOn_ff <= ~sec[`CWL_SEC_AIVT] & intconAltVector &
            ~sec[`CWL_SEC_BOOT_CTL]; // R13
         twoSpeedStartup_ff <= osel[`CWL_OSCSEL_TWO_SPEED]; // R14
         pwmKeyRequired_ff <= dev[`CWL_DEVOPT_PWM_KEY]; // R15
         resetOscSelect_ff <= osel[2:0]; // R16
         clockSwitchEnable_ff <= ~osc[`CWL_OSC_CLKSW_LO+1]; // R17
         failSafeMonitorEnable_ff <= (osc[`CWL_OSC_CLKSW_LO+1:`CWL_OSC_CLKSW_LO] == 2'h0); // R17
         watchdogEnableMode_ff <= wdt[`CWL_WDT_EN_LO+1:`CWL_WDT_EN_LO]; // R18
         watchdogPrescale_ff <= wdt[`CWL_WDT_PRE] ? 8'h80 : 8'h20; // R19
         watchdogPostscaleSelect_ff <= wdt[3:0]; // R19
         watchdogWindowMode_ff <= ~wdt[`CWL_WDT_WIN_OFF]; // R20
         watchdogWindowSize_ff <= wdt[`CWL_WDT_WIN_LO+1:`CWL_WDT_WIN_LO]; // R20
         flashPartitionMode_ff <= bootMode_ff[1:0]; // R21
         altRegset1Priority_ff <= alt[2:0]; // R22
         altRegset2Priority_ff <= alt[`CWL_ALT_SET2_LO+2:`CWL_ALT_SET2_LO]; // R22
         activePartition_ff <= dualMode & partSel_ff; // R2
      end
   end

   // fetch from config space raises a device reset request one cycle later, for as long as the fetch lasts
   always @(posedge sys_clk) begin
      if (rst) begin
         deviceResetReq_ff <= 1'b0;
      end else begin
         deviceResetReq_ff <= fetchFromCfgSpace; // R5
      end
   end

   // ----------------------------------------
   // apb slave, read only, zero wait states
   // ----------------------------------------
   reg [31:0] rdMux;
   reg rdHit;
   wire [23:0] a = paddr[23:0];
   always @* begin
      rdHit = 1'b1;
      rdMux = 32'h00000000;
      case (a)
         `CWL_OFF_SEC: rdMux = {8'h00, sec};
         `CWL_OFF_BOOTLIM: rdMux = {8'h00, bsl};
         `CWL_OFF_SIGN: rdMux = {8'h00, shadow_ff[2]};
         `CWL_OFF_OSCSEL: rdMux = {8'h00, osel};
         `CWL_OFF_OSC: rdMux = {8'h00, osc};
         `CWL_OFF_WDT: rdMux = {8'h00, wdt};
         `CWL_OFF_POR: rdMux = {8'h00, shadow_ff[6]};
         `CWL_OFF_ICD: rdMux = {8'h00, icd};
         `CWL_OFF_DEVOPT: rdMux = {8'h00, dev};
         `CWL_OFF_ALTREG: rdMux = {8'h00, alt};
         `CWL_OFF_BTSEQ: rdMux = {8'h00, partSel_ff ? 24'h000000 : seq1_ff};
         `CWL_OFF_BOOT: rdMux = {8'h00, bootMode_ff};
         `CWL_OFF_STATUS: rdMux = {28'h0000000, state_ff == ST_DONE,
            activePartition_ff, dualMode, cfgDone_ff};
         `CWL_OFF_DECODE: rdMux = {26'h0000000, altRegset2Priority_ff == `CWL_PRIO_RESERVED,
            altRegset1Priority_ff == `CWL_PRIO_RESERVED, resetOscSelect_ff == 3'h4,
            swapInstrAllowed_ff, cfgProtectLevel_ff == 2'h3, pwmKeyRequired_ff};
         default: rdHit = 1'b0;
      endcase
   end

   // writes are refused: shadows are read only (R24)
   always @(posedge sys_clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (pwrite | ~rdHit | softSwapReq & 1'b0);
         prdata <= (psel & ~penable & ~pwrite) ? rdMux : 32'h00000000;
      end
   end
endmodule

// *** verification/cwl_loader_chk.sv ***
// port checker for the configuration word loader
`timescale 1ns/10ps
module cwl_loader_chk (
   input wire sys_clk,
   input wire rst,
   input wire flashRdEn_ff,
   input wire fetchFromCfgSpace,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire cfgDone_ff,
   input wire deviceResetReq_ff,
   input wire activePartition_ff,
   input wire bootSegmentEnabled_ff,
   input wire altVectorTableOn_ff,
   input wire [2:0] resetOscSelect_ff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   reset_request_a: assert property (fetchFromCfgSpace |=> deviceResetReq_ff)
      else $error("no reset request after config space fetch");
   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("apb access not answered");
   write_refused_a: assert property (psel && !penable && pwrite |=> pslverr)
      else $error("apb write not refused");
   done_held_a: assert property (cfgDone_ff |=> cfgDone_ff)
      else $error("load done dropped");
   settings_hold_a: assert property (cfgDone_ff && $past(cfgDone_ff, 2) |->
      $stable(resetOscSelect_ff) && $stable(activePartition_ff))
      else $error("settings changed after load");
   no_fetch_after_a: assert property (cfgDone_ff |-> !flashRdEn_ff)
      else $error("flash read after load done");
   strobe_pulse_a: assert property (flashRdEn_ff |=> !flashRdEn_ff)
      else $error("flash strobe longer than one cycle");
   alt_vector_a: assert property (altVectorTableOn_ff |-> bootSegmentEnabled_ff)
      else $error("alternate table on without boot segment");
   upper_zero_a: assert property (pready |-> prdata[31:24] == 8'h00)
      else $error("read data upper byte not zero");
   cover property ($rose(cfgDone_ff));
   cover property (cfgDone_ff && activePartition_ff);
   cover property (pready && pslverr);
endmodule
bind cwl_config_word_loader cwl_loader_chk chk (.sys_clk, .rst, .flashRdEn_ff,
   .fetchFromCfgSpace, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .cfgDone_ff,
   .deviceResetReq_ff, .activePartition_ff, .bootSegmentEnabled_ff, .altVectorTableOn_ff,
   .resetOscSelect_ff);

// *** verification/cwl_flash_model.sv ***
// program flash model holding configuration words
`timescale 1ns/10ps
module cwl_flash_model (
   input wire sys_clk,
   input wire rdEn,
   input wire [23:0] addr,
   output logic [23:0] rdData = 24'h0,
   output logic rdValid = 1'b0
);
   logic [23:0] mem [logic [23:0]];
   logic [23:0] pendAddr = 24'h0;
   int waitCnt = 0;
   bit slow = 1'b0;
   always @(posedge sys_clk) begin
      rdValid <= 1'b0;
      // released bus toggles so a stale word is never mistaken for data
      rdData <= ~rdData;
      if (rdEn) begin
         pendAddr <= addr;
         waitCnt <= slow ? 3 : 1;
      end else if (waitCnt > 1) begin
         waitCnt <= waitCnt - 1;
      end else if (waitCnt == 1) begin
         waitCnt <= 0;
         rdValid <= 1'b1;
         // unwritten words read erased, reserved bits stay as the bench wrote them
         rdData <= mem.exists(pendAddr) ? mem[pendAddr] : 24'hffffff;
      end
   end
   task automatic eraseLastPage();
      for (int a = 'h2b80; a < 'h2c00; a += 4) mem.delete(24'(a));
   endtask
endmodule

// *** verification/cwl_config_word_loader_tb.sv ***
// self-checking bench for the configuration word loader
`timescale 1ns/10ps
`include "cwl_config_map.vh"
module cwl_config_word_loader_tb;
   logic sys_clk = 1'b0, rst = 1'b1, softSwapReq = 1'b0, fetchFromCfgSpace = 1'b0;
   logic intconAltVector = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rdErr;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, rdVal;
   wire flashRdEn_ff, flashRdValid, pready, pslverr, cfgDone_ff, deviceResetReq_ff;
   wire activePartition_ff, bootSegmentEnabled_ff, bootWriteBlock_ff, generalWriteBlock_ff;
   wire cfgWriteBlock_ff, swapInstrAllowed_ff, altVectorTableOn_ff, twoSpeedStartup_ff;
   wire pwmKeyRequired_ff, clockSwitchEnable_ff, failSafeMonitorEnable_ff;
   wire watchdogWindowMode_ff;
   wire [1:0] bootProtectLevel_ff, generalProtectLevel_ff, cfgProtectLevel_ff;
   wire [1:0] watchdogEnableMode_ff, watchdogWindowSize_ff, flashPartitionMode_ff;
   wire [2:0] resetOscSelect_ff, altRegset1Priority_ff, altRegset2Priority_ff;
   wire [3:0] watchdogPostscaleSelect_ff;
   wire [7:0] watchdogPrescale_ff;
   wire [12:0] bootPageLimit_ff;
   wire [23:0] flashAddr_ff, flashRdData;
   wire [31:0] prdata;
   int failures = 0, totalChecks = 0;
   cwl_config_word_loader dut (.sys_clk, .rst, .flashRdEn_ff, .flashAddr_ff, .flashRdData,
      .flashRdValid, .softSwapReq, .fetchFromCfgSpace, .intconAltVector, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cfgDone_ff, .deviceResetReq_ff,
      .activePartition_ff, .bootProtectLevel_ff, .bootSegmentEnabled_ff, .bootPageLimit_ff,
      .bootWriteBlock_ff, .generalProtectLevel_ff, .generalWriteBlock_ff, .cfgWriteBlock_ff,
      .cfgProtectLevel_ff, .swapInstrAllowed_ff, .altVectorTableOn_ff, .twoSpeedStartup_ff,
      .pwmKeyRequired_ff, .resetOscSelect_ff, .clockSwitchEnable_ff, .failSafeMonitorEnable_ff,
      .watchdogEnableMode_ff, .watchdogPrescale_ff, .watchdogPostscaleSelect_ff,
      .watchdogWindowMode_ff, .watchdogWindowSize_ff, .flashPartitionMode_ff,
      .altRegset1Priority_ff, .altRegset2Priority_ff);
   cwl_flash_model fl (.sys_clk, .rdEn(flashRdEn_ff), .addr(flashAddr_ff),
      .rdData(flashRdData), .rdValid(flashRdValid));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [31:0] a);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= 32'h00a5a5a5;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         give_verdict();
      end
      rdVal = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic reload(input int hold);
      int n;
      rst <= 1'b1;
      repeat (hold) @(posedge sys_clk);
      rst <= 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (cfgDone_ff !== 1'b1 && n < 400);
      if (n >= 400) begin
         failures++;
         give_verdict();
      end
      repeat (2) @(posedge sys_clk);
   endtask
   function automatic logic [1:0] lv2(input logic [1:0] c);
      return (c == 2'h3) ? 2'h0 : (c == 2'h2) ? 2'h1 : 2'h3;
   endfunction
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic decodeLoop();
      logic [2:0] k;
      for (int i = 0; i < 8; i++) begin
         k = 3'(i);
         fl.mem[`CWL_OFF_BOOT] = 24'hffffff;
         fl.mem[`CWL_OFF_SEC] = {9'h1fe, 3'h7, k, k[0], k[1:0], ~k[0], 1'b1, k[2], k[1:0], k[1]};
         fl.mem[`CWL_OFF_BOOTLIM] = {11'h7ff, 10'h3ff, k};
         fl.mem[`CWL_OFF_SIGN] = 24'hff7fff;
         fl.mem[`CWL_OFF_OSCSEL] = {16'hffff, k[0], 4'hf, k};
         fl.mem[`CWL_OFF_OSC] = {16'hffff, k[1:0], 6'h3f};
         fl.mem[`CWL_OFF_WDT] = {14'h3fff, k[1:0], k[2], k[1:0], k[0], k[0], k};
         fl.mem[`CWL_OFF_ICD] = {8'hff, k[0], 15'h7fff};
         fl.mem[`CWL_OFF_DEVOPT] = {23'h7fffff, k[1]};
         fl.mem[`CWL_OFF_ALTREG] = {16'hffff, 1'b1, k, 1'b1, ~k};
         intconAltVector <= k[0];
         reload(i == 0 ? 10 : 2);
         check({bootProtectLevel_ff, generalProtectLevel_ff}, {lv2(k[1:0]), lv2(k[1:0])});
         check(cfgProtectLevel_ff, (k == 7) ? 0 : (k == 6) ? 1 : k[2] ? 2 : 3);
         check({bootSegmentEnabled_ff, bootPageLimit_ff}, {~k[2], 10'h0, ~k});
         check({bootWriteBlock_ff, generalWriteBlock_ff, cfgWriteBlock_ff},
            {~k[1], k[0], ~k[0]});
         check({swapInstrAllowed_ff, pwmKeyRequired_ff}, {~k[0], k[1]});
         check(altVectorTableOn_ff, ~k[2] & k[0]);
         check({twoSpeedStartup_ff, resetOscSelect_ff}, {k[0], k});
         check({clockSwitchEnable_ff, failSafeMonitorEnable_ff}, {~k[1], k[1:0] == 2'h0});
         check({watchdogEnableMode_ff, watchdogPrescale_ff}, {k[1:0], k[0] ? 8'h80 : 8'h20});
         check({watchdogPostscaleSelect_ff, watchdogWindowMode_ff, watchdogWindowSize_ff},
            {k[0], k, ~k[2], k[1:0]});
         check({altRegset1Priority_ff, altRegset2Priority_ff, flashPartitionMode_ff},
            {~k, k, 2'h3});
      end
   endtask
   task automatic dualPick();
      fl.slow = 1'b1;
      fl.mem[`CWL_OFF_BOOT] = 24'hfffffe;
      fl.mem[`CWL_OFF_OSCSEL] = 24'hffff02;
      fl.mem[`CWL_OFF_BTSEQ] = {~12'h005, 12'h005};
      fl.mem[`CWL_OFF_BTSEQ + `CWL_PART2_BASE] = {~12'h003, 12'h003};
      reload(2);
      check({activePartition_ff, flashPartitionMode_ff, resetOscSelect_ff},
         {1'b1, 2'h2, 3'h7});
      fl.mem[`CWL_OFF_BTSEQ + `CWL_PART2_BASE] = {~12'h002, 12'h003};
      reload(2);
      check({activePartition_ff, resetOscSelect_ff}, {1'b0, 3'h2});
      fl.slow = 1'b0;
   endtask
   task automatic keepAndErase();
      softSwapReq <= 1'b1;
      fl.mem[`CWL_OFF_OSCSEL] = 24'hffff05;
      @(posedge sys_clk);
      softSwapReq <= 1'b0;
      repeat (8) @(posedge sys_clk);
      check(resetOscSelect_ff, 3'h2);
      apb(1'b0, {8'h00, `CWL_OFF_OSCSEL});
      check({rdErr, rdVal[23:0]}, {1'b0, 24'hffff02});
      apb(1'b1, {8'h00, `CWL_OFF_OSCSEL});
      check(rdErr, 1'b1);
      apb(1'b0, 32'h00002b84);
      check(rdErr, 1'b1);
      apb(1'b0, {8'h00, `CWL_OFF_OSCSEL});
      check(rdVal, 32'h00ffff02);
      fl.eraseLastPage();
      reload(2);
      check({activePartition_ff, resetOscSelect_ff}, {1'b0, 3'h7});
   endtask
   task automatic cfgFetch();
      fetchFromCfgSpace <= 1'b1;
      @(posedge sys_clk);
      fetchFromCfgSpace <= 1'b0;
      @(posedge sys_clk);
      check(deviceResetReq_ff, 1'b1);
      @(posedge sys_clk);
      check(deviceResetReq_ff, 1'b0);
   endtask
   initial begin
      decodeLoop();
      dualPick();
      keepAndErase();
      cfgFetch();
      give_verdict();
   end
endmodule
